// >>> core/flash_self_program_pkg.sv
// Shared constants and types for the flash self-programming controller
package flash_self_program_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] LOCK_OFF = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
    localparam logic [7:0] LAYOUT_OFF = 8'h14;

    // Control bits
    localparam int CTRL_BUSY_CLR_BIT = 0;
    localparam int CTRL_CHIP_ERASE_BIT = 1;

    // Status bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int ST_STALL_BIT = 2;

    // Event bits and width
    localparam int EV_DONE_BIT = 0;
    localparam int EV_REFUSED_BIT = 1;
    localparam int EV_W = 2;

    // Lock pair layout: [1:0] application, [3:2] boot section
    localparam int LOCK_W = 4;
    localparam int APP_LO = 0;
    localparam int BOOT_LO = 2;
    localparam logic [3:0] LOCK_RESET = 4'hF;
    localparam int LOCK_WR_BIT = 0;
    localparam int LOCK_RD_BIT = 1;

    // Layout register field positions
    localparam int LAYOUT_VEC_LO = 16;

    // Application reset address
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Controller states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONC = 3'b010,
        ST_HALT = 3'b100
    } prog_state_t;

    // Store-program request from the core
    typedef struct packed {
        logic erase;
        logic [15:0] exec_addr;
        logic [15:0] target_addr;
    } prog_req_t;

    // Command to the flash array
    typedef struct packed {
        logic start;
        logic erase;
        logic [15:0] page_addr;
    } flash_cmd_t;

endpackage

// >>> core/flash_self_program.sv
// Flash self-programming section, region and lock control with AXI4-Lite registers
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps

module flash_self_program #(
    parameter int AW = 16,
    parameter int PAGE_W = 6,
    parameter logic [15:0] FLASH_TOP = 16'h7FFF,
    parameter logic [15:0] STALL_BASE = 16'h7000,
    parameter logic [15:0] BOOT_SIZE_0 = 16'h1000,
    parameter logic [15:0] BOOT_SIZE_1 = 16'h0800,
    parameter logic [15:0] BOOT_SIZE_2 = 16'h0400,
    parameter logic [15:0] BOOT_SIZE_3 = 16'h0200
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Fuses
    input wire logic [1:0] boot_size_fuses,
    input wire logic boot_reset_select_fuse,
    // Core store-program and program read
    input wire logic prog_valid,
    input wire flash_self_program_pkg::prog_req_t prog_req,
    input wire logic rd_valid,
    input wire logic [AW-1:0] rd_addr,
    input wire logic [AW-1:0] rd_exec_addr,
    output logic rd_ok,
    output logic core_stall,
    output logic [AW-1:0] reset_vector,
    // Flash array
    output flash_self_program_pkg::flash_cmd_t flash_cmd,
    input wire logic flash_done,
    // Interrupt
    output logic irq
);

    // Boot section start from fuses, never below the stalling region
    function automatic logic [AW-1:0] boot_start(input logic [1:0] sz);
        logic [15:0] size;
        logic [15:0] start;
        unique case (sz)
            2'b00: size = BOOT_SIZE_0;
            2'b01: size = BOOT_SIZE_1;
            2'b10: size = BOOT_SIZE_2;
            2'b11: size = BOOT_SIZE_3;
        endcase
        start = FLASH_TOP - size + 16'h0001;
        if (start < STALL_BASE) begin
            start = STALL_BASE;
        end
        return start[AW-1:0];
    endfunction

    // Lock pair selected by section of an address
    function automatic logic [1:0] pair_of(input logic in_boot, input logic [3:0] lk);
        return in_boot ? lk[flash_self_program_pkg::BOOT_LO +: 2]
                       : lk[flash_self_program_pkg::APP_LO +: 2];
    endfunction

    flash_self_program_pkg::prog_state_t state_reg, state_next;
    logic busy_reg, busy_next;
    logic stall_reg, stall_next;
    logic [3:0] lock_reg, lock_next;
    logic [1:0] ev_reg, ev_next;
    logic [1:0] mask_reg, mask_next;
    flash_self_program_pkg::flash_cmd_t cmd_reg, cmd_next;
    logic rd_ok_reg, rd_ok_next;
    logic [AW-1:0] vec_reg, vec_next;
    logic irq_reg, irq_next;
    logic awready_reg, awready_next, arready_reg, arready_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [AW-1:0] bstart;
    logic exec_boot, tgt_boot, tgt_stall, wr_locked, start_ok, wr_fire, rd_fire;
    logic [1:0] ev_set, tgt_pair, rd_pair;

    // Section decode for the store-program request
    always_comb begin
        bstart = boot_start(boot_size_fuses);
        exec_boot = prog_req.exec_addr >= bstart;
        tgt_boot = prog_req.target_addr >= bstart;
        tgt_stall = prog_req.target_addr >= STALL_BASE;
        tgt_pair = pair_of(tgt_boot, lock_reg);
        wr_locked = !tgt_pair[flash_self_program_pkg::LOCK_WR_BIT];
        start_ok = prog_valid && exec_boot && !wr_locked
                   && (state_reg == flash_self_program_pkg::ST_IDLE);
    end

    // AXI handshake and event decode
    always_comb begin
        wr_fire = awready_reg;
        rd_fire = arready_reg;
        ev_set = '0;
        ev_set[flash_self_program_pkg::EV_DONE_BIT] =
            flash_done && (state_reg != flash_self_program_pkg::ST_IDLE);
        ev_set[flash_self_program_pkg::EV_REFUSED_BIT] = prog_valid && !start_ok;
    end

    // Programming sequencer next state
    always_comb begin
        state_next = state_reg;
        busy_next = busy_reg;
        stall_next = stall_reg;
        cmd_next = cmd_reg;
        cmd_next.start = 1'b0;
        unique case (state_reg)
            flash_self_program_pkg::ST_IDLE: begin
                if (start_ok) begin
                    cmd_next.start = 1'b1;
                    cmd_next.erase = prog_req.erase;
                    cmd_next.page_addr = {prog_req.target_addr[15:PAGE_W], {PAGE_W{1'b0}}};
                    if (tgt_stall) begin
                        state_next = flash_self_program_pkg::ST_HALT;
                        stall_next = 1'b1;
                    end else begin
                        state_next = flash_self_program_pkg::ST_CONC;
                    end
                end
            end
            flash_self_program_pkg::ST_CONC: begin
                if (flash_done) begin
                    state_next = flash_self_program_pkg::ST_IDLE;
                end
            end
            flash_self_program_pkg::ST_HALT: begin
                if (flash_done) begin
                    state_next = flash_self_program_pkg::ST_IDLE;
                    stall_next = 1'b0;
                end
            end
            default: begin
                state_next = flash_self_program_pkg::ST_IDLE;
                stall_next = 1'b0;
            end
        endcase
        // Software clear loses to a new concurrent start
        if (wr_fire && awaddr == flash_self_program_pkg::CTRL_OFF && wstrb[0]
            && wdata[flash_self_program_pkg::CTRL_BUSY_CLR_BIT]
            && state_reg == flash_self_program_pkg::ST_IDLE) begin
            busy_next = 1'b0;
        end
        if (start_ok && !tgt_stall) begin
            busy_next = 1'b1;
        end
    end

    // Program read gating, registered grant
    always_comb begin
        logic rd_boot;
        logic ex_boot;
        rd_boot = 1'b0;
        ex_boot = 1'b0;
        rd_boot = rd_addr >= bstart;
        ex_boot = rd_exec_addr >= bstart;
        rd_pair = pair_of(rd_boot, lock_reg);
        rd_ok_next = rd_valid && !stall_reg;
        if (busy_reg && rd_addr < STALL_BASE) begin
            rd_ok_next = 1'b0;
        end
        if (rd_boot != ex_boot
            && !rd_pair[flash_self_program_pkg::LOCK_RD_BIT]) begin
            rd_ok_next = 1'b0;
        end
    end

    // Register file, interrupt and reset vector next values
    always_comb begin
        lock_next = lock_reg;
        mask_next = mask_reg;
        ev_next = ev_reg;
        if (wr_fire && wstrb[0]) begin
            unique case (awaddr)
                flash_self_program_pkg::LOCK_OFF:
                    lock_next = lock_reg & wdata[3:0];
                flash_self_program_pkg::IRQ_MASK_OFF:
                    mask_next = wdata[1:0];
                flash_self_program_pkg::IRQ_STAT_OFF:
                    ev_next = ev_reg & ~wdata[1:0];
                flash_self_program_pkg::CTRL_OFF:
                    if (wdata[flash_self_program_pkg::CTRL_CHIP_ERASE_BIT]) begin
                        lock_next = flash_self_program_pkg::LOCK_RESET;
                    end
                default: ;
            endcase
        end
        ev_next = ev_next | ev_set;
        irq_next = |(ev_next & mask_next);
        vec_next = boot_reset_select_fuse ? flash_self_program_pkg::APP_RESET_ADDR[AW-1:0]
                                          : bstart;
    end

    // AXI4-Lite slave channel next values
    always_comb begin
        awready_next = awvalid && wvalid && !awready_reg && !bvalid_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            bvalid_next = 1'b1;
            bresp_next = (awaddr > flash_self_program_pkg::LAYOUT_OFF || awaddr[1:0] != 2'b00)
                         ? flash_self_program_pkg::RESP_SLVERR : flash_self_program_pkg::RESP_OKAY;
        end
        arready_next = arvalid && !arready_reg && !rvalid_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next = flash_self_program_pkg::RESP_OKAY;
            rdata_next = 32'h0000_0000;
            unique case (araddr)
                flash_self_program_pkg::CTRL_OFF: rdata_next = 32'h0000_0000;
                flash_self_program_pkg::STATUS_OFF: begin
                    rdata_next[flash_self_program_pkg::ST_BUSY_BIT] = busy_reg;
                    rdata_next[flash_self_program_pkg::ST_ACTIVE_BIT] =
                        state_reg != flash_self_program_pkg::ST_IDLE;
                    rdata_next[flash_self_program_pkg::ST_STALL_BIT] = stall_reg;
                end
                flash_self_program_pkg::LOCK_OFF: rdata_next[3:0] = lock_reg;
                flash_self_program_pkg::IRQ_STAT_OFF: rdata_next[1:0] = ev_reg;
                flash_self_program_pkg::IRQ_MASK_OFF: rdata_next[1:0] = mask_reg;
                flash_self_program_pkg::LAYOUT_OFF: begin
                    rdata_next[AW-1:0] = bstart;
                    rdata_next[flash_self_program_pkg::LAYOUT_VEC_LO +: AW] = vec_reg;
                end
                default: rresp_next = flash_self_program_pkg::RESP_SLVERR;
            endcase
        end
    end

    // All state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= flash_self_program_pkg::ST_IDLE;
            busy_reg <= 1'b0;
            stall_reg <= 1'b0;
            cmd_reg <= '0;
            lock_reg <= flash_self_program_pkg::LOCK_RESET;
            ev_reg <= '0;
            mask_reg <= '0;
            irq_reg <= 1'b0;
            rd_ok_reg <= 1'b0;
            vec_reg <= '0;
            awready_reg <= 1'b0;
            arready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            bresp_reg <= '0;
            rresp_reg <= '0;
            rdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            busy_reg <= busy_next;
            stall_reg <= stall_next;
            cmd_reg <= cmd_next;
            lock_reg <= lock_next;
            ev_reg <= ev_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            rd_ok_reg <= rd_ok_next;
            vec_reg <= vec_next;
            awready_reg <= awready_next;
            arready_reg <= arready_next;
            bvalid_reg <= bvalid_next;
            rvalid_reg <= rvalid_next;
            bresp_reg <= bresp_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // Output drive
    assign awready = awready_reg;
    assign wready = awready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign rd_ok = rd_ok_reg;
    assign core_stall = stall_reg;
    assign reset_vector = vec_reg;
    assign flash_cmd = cmd_reg;
    assign irq = irq_reg;

    // Checks
    sequence app_request_s;
        prog_valid && !exec_boot;
    endsequence
    sequence idle_request_s;
        prog_valid && state_reg == flash_self_program_pkg::ST_IDLE;
    endsequence

    app_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        app_request_s |=> !cmd_reg.start) else $error("store-program from application started");
    halt_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        idle_request_s ##0 (start_ok && tgt_stall) |=> core_stall && cmd_reg.start)
        else $error("stalling-region operation did not halt core");
    halt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == flash_self_program_pkg::ST_HALT && !flash_done) |=> core_stall)
        else $error("core released before operation end");
    conc_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (start_ok && !tgt_stall) |=> busy_reg && !core_stall) else $error("busy flag not set");
    conc_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (busy_reg && rd_addr < STALL_BASE) |=> !rd_ok) else $error("blocked region read granted");
    busy_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (busy_reg && !wr_fire) |=> busy_reg) else $error("busy flag dropped without software");
    lock_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wr_fire && awaddr == flash_self_program_pkg::CTRL_OFF)
        |=> (lock_reg & ~$past(lock_reg)) == 4'h0) else $error("lock bit unprogrammed");
    vector_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_reset_select_fuse ##1 boot_reset_select_fuse |-> reset_vector == '0)
        else $error("reset vector not application address");
    boot_inside_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bstart >= STALL_BASE) else $error("boot section reaches concurrent region");
    write_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (prog_valid && wr_locked) |=> !cmd_reg.start) else $error("locked section written");

endmodule // flash_self_program

// >>> sim/flash_array_model.sv
// Behavioural flash array answering program commands after a set delay
`timescale 1ns/100ps

module flash_array_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Command side
    input wire flash_self_program_pkg::flash_cmd_t flash_cmd,
    input wire logic [7:0] op_cycles,
    output logic flash_done,
    // Observation
    output int starts,
    output logic [16:0] last_cmd
);
    int cnt;

    // Count down each accepted command, then pulse done for one cycle
    always @(posedge aclk) begin
        flash_done <= 1'b0;
        if (!aresetn) begin
            cnt <= 0;
            starts <= 0;
            last_cmd <= 17'h0_0000;
        end else if (flash_cmd.start) begin
            cnt <= int'(op_cycles);
            starts <= starts + 1;
            last_cmd <= {flash_cmd.erase, flash_cmd.page_addr};
        end else if (cnt == 1) begin
            cnt <= 0;
            flash_done <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // flash_array_model

// >>> sim/flash_self_program_bench.sv
// Self-checking testbench for the flash self-programming controller
`timescale 1ns/100ps

module flash_self_program_bench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, boot_reset_select_fuse, prog_valid, rd_valid;
    logic rd_ok, core_stall, flash_done, irq;
    logic [7:0] awaddr, araddr, op_cycles;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, boot_size_fuses, r;
    logic [15:0] rd_addr, rd_exec_addr, reset_vector;
    logic [16:0] last_cmd;
    flash_self_program_pkg::prog_req_t prog_req;
    flash_self_program_pkg::flash_cmd_t flash_cmd;
    int starts, bad_count, n_checks, j;
    // Expected boot section start per fuse value
    logic [15:0] bstart [4] = '{16'h7000, 16'h7800, 16'h7C00, 16'h7E00};

    flash_self_program u_flash_self_program (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .boot_size_fuses, .boot_reset_select_fuse,
        .prog_valid, .prog_req, .rd_valid, .rd_addr, .rd_exec_addr, .rd_ok, .core_stall,
        .reset_vector, .flash_cmd, .flash_done, .irq);

    flash_array_model u_flash_array_model (.aclk, .aresetn, .flash_cmd, .op_cycles,
        .flash_done, .starts, .last_cmd);

    // Clock generation
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (awready) begin
                awvalid <= 1'b0;
            end
            if (wready) begin
                wvalid <= 1'b0;
            end
            k++;
        end while (bvalid !== 1'b1 && k < 40);
        r = bresp;
        bready <= 1'b0;
        if (k >= 40) begin
            chk(0, 1, "write timed out");
            end_sim();
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (arready) begin
                arvalid <= 1'b0;
            end
            k++;
        end while (rvalid !== 1'b1 && k < 40);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        if (k >= 40) begin
            chk(0, 1, "read timed out");
            end_sim();
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a, d);
        chk(d & m, e, "register value");
    endtask

    // Program fetch, permission answered one cycle later
    task automatic rdq(input logic [15:0] a, input logic [15:0] x, input logic e);
        @(posedge aclk);
        rd_addr <= a;
        rd_exec_addr <= x;
        rd_valid <= 1'b1;
        @(posedge aclk);
        rd_valid <= 1'b0;
        #1;
        chk(rd_ok, e, "fetch permission");
    endtask

    task automatic prog(input logic e, input logic [15:0] x, input logic [15:0] t);
        @(posedge aclk);
        prog_req <= '{e, x, t};
        prog_valid <= 1'b1;
        @(posedge aclk);
        prog_valid <= 1'b0;
        @(posedge aclk);
        #1;
    endtask

    task automatic idle();
        int k;
        for (k = 0; k < 40; k++) begin
            rd(flash_self_program_pkg::STATUS_OFF, d);
            if (d[1] === 1'b0) break;
        end
        if (k == 40) begin
            chk(0, 1, "operation never ended");
            end_sim();
        end
    endtask

    task automatic rst();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, prog_valid, rd_valid} = 8'h00;
        {awaddr, araddr, wdata, wstrb, rd_addr, rd_exec_addr} = 84'h0;
        prog_req = '0;
        op_cycles = 8'h1E;
        boot_size_fuses = 2'h3;
        boot_reset_select_fuse = 1'b1;
        rst();
        chk(reset_vector, 16'h0000, "application reset vector");
        for (j = 0; j < 4; j++) begin
            boot_size_fuses <= j[1:0];
            rd(flash_self_program_pkg::LAYOUT_OFF, d);
            chk(d[15:0], bstart[j], "boot start");
            chk(d[15:0] >= 16'h7000, 1, "boot inside stalling region");
        end
        $display("test layout done");
        prog(1'b0, 16'h0100, 16'h0040);
        chk(starts, 0, "start from application");
        rchk(flash_self_program_pkg::IRQ_STAT_OFF, 32'h0000_0003, 32'h0000_0002);
        chk(irq, 0, "irq while masked");
        wr(flash_self_program_pkg::IRQ_MASK_OFF, 32'h0000_0003);
        repeat (2) @(posedge aclk);
        chk(irq, 1, "irq unmasked");
        wr(flash_self_program_pkg::IRQ_STAT_OFF, 32'h0000_0003);
        repeat (2) @(posedge aclk);
        chk(irq, 0, "irq cleared");
        $display("test refusal done");
        prog(1'b0, 16'h7E00, 16'h0040);
        chk(starts, 1, "concurrent region start");
        chk(core_stall, 0, "no stall");
        rdq(16'h7F3B, 16'h7E00, 1'b1);
        rdq(16'h0010, 16'h7E00, 1'b0);
        rchk(flash_self_program_pkg::STATUS_OFF, 32'h0000_0003, 32'h0000_0003);
        idle();
        chk(last_cmd, 17'h0_0040, "write page");
        rchk(flash_self_program_pkg::STATUS_OFF, 32'h0000_0001, 32'h0000_0001);
        rdq(16'h0010, 16'h7E00, 1'b0);
        chk(irq, 1, "done irq");
        wr(flash_self_program_pkg::CTRL_OFF, 32'h0000_0001);
        rchk(flash_self_program_pkg::STATUS_OFF, 32'h0000_0001, 32'h0000_0000);
        rdq(16'h0010, 16'h7E00, 1'b1);
        $display("test concurrent done");
        wr(flash_self_program_pkg::IRQ_STAT_OFF, 32'h0000_0003);
        op_cycles <= 8'h04;
        prog(1'b1, 16'h7E00, 16'h7E40);
        chk(core_stall, 1, "stall on boot page");
        idle();
        chk(core_stall, 0, "stall released");
        chk(last_cmd, 17'h1_7E40, "erase page");
        rchk(flash_self_program_pkg::STATUS_OFF, 32'h0000_0001, 32'h0000_0000);
        $display("test stalling done");
        wr(flash_self_program_pkg::LOCK_OFF, 32'h0000_000D);
        rdq(16'h0010, 16'h7E00, 1'b0);
        rdq(16'h0010, 16'h0100, 1'b1);
        wr(flash_self_program_pkg::LOCK_OFF, 32'h0000_000E);
        rchk(flash_self_program_pkg::LOCK_OFF, 32'h0000_000F, 32'h0000_000C);
        prog(1'b0, 16'h7E00, 16'h0040);
        chk(starts, 2, "application write locked");
        wr(flash_self_program_pkg::LOCK_OFF, 32'h0000_000B);
        prog(1'b0, 16'h7E00, 16'h7E40);
        chk(starts, 2, "boot write locked");
        wr(flash_self_program_pkg::LOCK_OFF, 32'h0000_0007);
        rdq(16'h7F00, 16'h0100, 1'b0);
        wr(flash_self_program_pkg::CTRL_OFF, 32'h0000_0002);
        rchk(flash_self_program_pkg::LOCK_OFF, 32'h0000_000F, 32'h0000_000F);
        $display("test locks done");
        rd(8'h18, d);
        chk(r, flash_self_program_pkg::RESP_SLVERR, "unmapped read");
        wr(8'h18, 32'h0000_0000);
        chk(r, flash_self_program_pkg::RESP_SLVERR, "unmapped write");
        boot_reset_select_fuse <= 1'b0;
        rst();
        chk(reset_vector, 16'h7E00, "boot reset vector");
        rchk(flash_self_program_pkg::LAYOUT_OFF, 32'hFFFF_0000, 32'h7E00_0000);
        $display("test reset vector done");
        end_sim();
    end
endmodule // flash_self_program_bench
